//--- pwp_map.svh
/*
  Register offsets, field positions and reset values for the peripheral
  write-protect banks. Assumes a 32-bit AXI4-Lite register window.
*/
`ifndef PWP_MAP_SVH
`define PWP_MAP_SVH
`define PWP_B_CLR_OFS 12'h000
`define PWP_B_SET_OFS 12'h004
`define PWP_C_CLR_OFS 12'h010
`define PWP_C_SET_OFS 12'h014
`define PWP_TGT_OFS 12'h020
`define PWP_ERR_OFS 12'h024
`define PWP_B_MASK 32'h0000000e
`define PWP_C_MASK 32'h000ffffe
`define PWP_B_RST 32'h00000002
`define PWP_C_RST 32'h00100000
`define PWP_C_FIXED 32'h00100000
`endif

//--- pwp_pkg.sv
/*
  Types for the peripheral write-protect banks.
  Assumes the map header supplies all offsets, masks and reset values.
*/
package pwp_pkg;
  typedef enum logic [1:0] {
    PWP_RESP_OKAY = 2'b00,
    PWP_RESP_SLVERR = 2'b10
  } pwp_resp_t;
  typedef logic [31:0] pwp_word_t;
endpackage

//--- pwp_bank.sv
/*
  One protection flag bank with set and clear views and double-action
  detection. Assumes write strobes are already qualified by the caller.
*/
module pwp_bank #(
  parameter logic [31:0] MASK = 32'h0000000e,
  parameter logic [31:0] RST = 32'h00000002,
  parameter logic [31:0] FIXED = 32'h00000000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic set_we,
  input wire logic clr_we,
  input wire logic [31:0] wdata,
  output logic [31:0] flags,
  output logic dbl_err
);
  logic [31:0] prot_ff;
  logic [31:0] nxt_prot;
  logic [31:0] req;
  always_comb
  begin
    req = wdata & MASK;
    nxt_prot = prot_ff;
    dbl_err = 1'b0;
    if (set_we)
    begin
      nxt_prot = prot_ff | req;
      dbl_err = |(prot_ff & req);
    end
    else if (clr_we)
    begin
      nxt_prot = prot_ff & ~req;
      dbl_err = |(~prot_ff & req);
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prot_ff <= RST & MASK;
    else if (ce)
      prot_ff <= nxt_prot;
  end
  // Reserved bits fixed, bit 0 reads zero
  assign flags = (prot_ff & MASK) | FIXED;
endmodule // pwp_bank

//--- pwp_top.sv
/*
  AXI4-Lite slave holding the second and third peripheral write-protect
  banks, plus a write gate for downstream peripheral writes.
  Assumes a single clock; peripheral select and debugger flag come from
  logic on the same clock.
*/
// Implementation choice: the AXI4-Lite slave port.
`include "pwp_map.svh"
module pwp_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic per_wr_req,
  input wire logic per_wr_group,
  input wire logic [4:0] per_wr_index,
  input wire logic per_wr_debug,
  output logic per_wr_allow,
  output logic per_wr_error,
  output logic [31:0] bank_b_flags,
  output logic [31:0] bank_c_flags
);
  logic aw_hold_ff, nxt_aw_hold;
  logic w_hold_ff, nxt_w_hold;
  logic [11:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic allow_ff, nxt_allow;
  logic perr_ff, nxt_perr;
  logic [31:0] bflags_ff, cflags_ff;
  logic [31:0] b_flags, c_flags;
  logic b_dbl, c_dbl;
  logic do_wr, b_set, b_clr, c_set, c_clr;
  logic [31:0] wmask;
  logic hit, tgt_prot;
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic arready_ff, nxt_arready;

  // Accept address and data in either order; write fires when both held
  assign do_wr = aw_hold_ff && w_hold_ff && !bvalid_ff;
  // Byte strobes widen to a bit mask; masked bytes act as zero
  for (genvar g = 0; g < 4; g++)
  begin : g_strb
    assign wmask[g*8 +: 8] = {8{wstrb_ff[g]}};
  end
  assign b_set = do_wr && awaddr_ff == `PWP_B_SET_OFS;
  assign b_clr = do_wr && awaddr_ff == `PWP_B_CLR_OFS;
  assign c_set = do_wr && awaddr_ff == `PWP_C_SET_OFS;
  assign c_clr = do_wr && awaddr_ff == `PWP_C_CLR_OFS;

  pwp_bank #(
    .MASK(`PWP_B_MASK),
    .RST(`PWP_B_RST),
    .FIXED(32'h00000000)
  ) u_bank_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(clk_en),
    .set_we(b_set),
    .clr_we(b_clr),
    .wdata(wdata_ff & wmask),
    .flags(b_flags),
    .dbl_err(b_dbl)
  );

  pwp_bank #(
    .MASK(`PWP_C_MASK),
    .RST(`PWP_C_RST),
    .FIXED(`PWP_C_FIXED)
  ) u_bank_c (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(clk_en),
    .set_we(c_set),
    .clr_we(c_clr),
    .wdata(wdata_ff & wmask),
    .flags(c_flags),
    .dbl_err(c_dbl)
  );

  always_comb
  begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (s_awvalid && !aw_hold_ff)
    begin
      nxt_aw_hold = 1'b1;
      nxt_awaddr = {s_awaddr[11:2], 2'b00};
    end
    if (s_wvalid && !w_hold_ff)
    begin
      nxt_w_hold = 1'b1;
      nxt_wdata = s_wdata;
      nxt_wstrb = s_wstrb;
    end
    if (do_wr)
    begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = pwp_pkg::PWP_RESP_OKAY;
      if (b_set || b_clr || c_set || c_clr)
      begin
        if (b_dbl || c_dbl)
          nxt_bresp = pwp_pkg::PWP_RESP_SLVERR;
      end
      else
        nxt_bresp = pwp_pkg::PWP_RESP_SLVERR;
    end
    else if (bvalid_ff && s_bready)
      nxt_bvalid = 1'b0;
    // Readies follow the hold flags one flop deep
    nxt_awready = !nxt_aw_hold;
    nxt_wready = !nxt_w_hold;
  end

  always_comb
  begin
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (s_arvalid && !rvalid_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = pwp_pkg::PWP_RESP_OKAY;
      unique case ({s_araddr[11:2], 2'b00})
        `PWP_B_SET_OFS, `PWP_B_CLR_OFS: nxt_rdata = b_flags;
        `PWP_C_SET_OFS, `PWP_C_CLR_OFS: nxt_rdata = c_flags;
        default:
        begin
          nxt_rdata = 32'h00000000;
          nxt_rresp = pwp_pkg::PWP_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && s_rready)
      nxt_rvalid = 1'b0;
    nxt_arready = !nxt_rvalid;
  end

  // Downstream peripheral write gate, answered one cycle after request
  always_comb
  begin
    hit = per_wr_index != 5'h00 && per_wr_index < 5'h14;
    tgt_prot = per_wr_group ? c_flags[per_wr_index]
                            : b_flags[per_wr_index];
    tgt_prot = tgt_prot && hit;
    nxt_allow = per_wr_req && (per_wr_debug || !tgt_prot);
    nxt_perr = per_wr_req && !per_wr_debug && tgt_prot;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h00000000;
      allow_ff <= 1'b0;
      perr_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      arready_ff <= 1'b1;
      bflags_ff <= `PWP_B_RST;
      cflags_ff <= `PWP_C_RST;
    end
    else if (clk_en)
    begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      allow_ff <= nxt_allow;
      perr_ff <= nxt_perr;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      arready_ff <= nxt_arready;
      bflags_ff <= b_flags;
      cflags_ff <= c_flags;
    end
  end

  assign s_awready = awready_ff;
  assign s_wready = wready_ff;
  assign s_bvalid = bvalid_ff;
  assign s_bresp = bresp_ff;
  assign s_arready = arready_ff;
  assign s_rvalid = rvalid_ff;
  assign s_rresp = rresp_ff;
  assign s_rdata = rdata_ff;
  assign per_wr_allow = allow_ff;
  assign per_wr_error = perr_ff;
  assign bank_b_flags = bflags_ff;
  assign bank_c_flags = cflags_ff;

  sequence set_write_s;
    do_wr && c_set && clk_en &&
      ((wdata_ff & wmask & `PWP_C_MASK) != 32'h0);
  endsequence

  set_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    set_write_s |=> ((c_flags & $past(wdata_ff & wmask
      & `PWP_C_MASK)) == $past(wdata_ff & wmask & `PWP_C_MASK)))
    else $error("set write did not protect");
  clr_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr && b_clr && clk_en |=> ((b_flags & $past(wdata_ff & wmask))
      == 32'h0))
    else $error("clear write did not unprotect");
  zero_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr && clk_en && (wdata_ff & wmask) == 32'h0 |=>
      $stable(b_flags) && $stable(c_flags))
    else $error("zero write changed flags");
  b_reserved_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bank_b_flags[31:4] == 28'h0 && bank_b_flags[0] == 1'b0)
    else $error("bank b reserved bits nonzero");
  c_reserved_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bank_c_flags[31:20] == 12'h001 && bank_c_flags[0] == 1'b0)
    else $error("bank c reserved bits wrong");
  dbl_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr && clk_en && (b_dbl || c_dbl) |=> s_bvalid &&
      s_bresp == 2'b10)
    else $error("double action not flagged");
  gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && per_wr_req && !per_wr_debug && tgt_prot |=>
      per_wr_error && !per_wr_allow)
    else $error("protected write not blocked");
  debug_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && per_wr_req && per_wr_debug |=> per_wr_allow &&
      !per_wr_error)
    else $error("debug write blocked");
  read_same_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && s_arvalid && !rvalid_ff && s_araddr == `PWP_C_CLR_OFS |=>
      s_rdata == $past(c_flags))
    else $error("clear view read mismatch");
  rst_val_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> bank_b_flags == `PWP_B_RST &&
      bank_c_flags == `PWP_C_RST)
    else $error("flags not at reset value");
  freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_en |=> $stable(bank_b_flags) && $stable(bank_c_flags) &&
      $stable(s_bvalid) && $stable(s_rvalid) && $stable(per_wr_allow))
    else $error("state moved while frozen");
  gate_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !per_wr_req |=> !per_wr_allow && !per_wr_error)
    else $error("gate answered without request");
  aw_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && s_awvalid && s_awready |=> !s_awready)
    else $error("address taken while one is held");
endmodule // pwp_top

//--- pwp_core_model.sv
/*
  Core-side model that issues peripheral write attempts to the gate.
  Assumes it shares aclk with the block and is called from the bench.
*/
module pwp_core_model (
  input wire logic aclk,
  output logic req,
  output logic grp,
  output logic [4:0] idx,
  output logic dbg
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    req = 1'b0;
    grp = 1'b0;
    idx = 5'h00;
    dbg = 1'b0;
  end
  // One-cycle attempt; fields are inverted once released
  task automatic attempt(input logic g, input logic [4:0] i, input logic d);
    @(posedge aclk);
    req <= 1'b1;
    grp <= g;
    idx <= i;
    dbg <= d;
    @(posedge aclk);
    req <= 1'b0;
    grp <= ~g;
    idx <= ~i;
    dbg <= ~d;
  endtask
endmodule // pwp_core_model

//--- peripheral_write_protect_banks_tb_top.sv
/*
  Self-checking bench for the write-protect banks and peripheral gate.
  Assumes one 50 MHz clock and the map header offsets.
*/
`include "pwp_map.svh"
module peripheral_write_protect_banks_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] OK = pwp_pkg::PWP_RESP_OKAY;
  localparam logic [1:0] ER = pwp_pkg::PWP_RESP_SLVERR;
  logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic per_wr_req, per_wr_group, per_wr_debug, per_wr_allow, per_wr_error;
  logic [4:0] per_wr_index;
  logic clk_en;
  logic [31:0] bank_b_flags, bank_c_flags;
  int miscompares, cmp_count, cyc;
  pwp_top dut (.aclk, .aresetn, .clk_en, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .per_wr_req, .per_wr_group,
    .per_wr_index, .per_wr_debug, .per_wr_allow, .per_wr_error,
    .bank_b_flags, .bank_c_flags);
  pwp_core_model core (.aclk, .req(per_wr_req), .grp(per_wr_group),
    .idx(per_wr_index), .dbg(per_wr_debug));
  task automatic results;
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] er);
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (1)
    begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) break;
    end
    s_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_bresp});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (1)
    begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) break;
    end
    s_rready <= 1'b0;
    chk("rdata", ed, s_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_rresp});
  endtask
  task automatic gate(input logic g, input logic [4:0] i, input logic d,
    input logic ea);
    core.attempt(g, i, d);
    #1;
    chk("allow", {31'h0, ea}, {31'h0, per_wr_allow});
    chk("error", {31'h0, !ea}, {31'h0, per_wr_error});
  endtask
  // Registered flag outputs, looked at well clear of the edge
  task automatic flags(input logic [31:0] eb, input logic [31:0] ec);
    @(posedge aclk);
    #1;
    chk("bank_b_flags", eb, bank_b_flags);
    chk("bank_c_flags", ec, bank_c_flags);
  endtask
  task automatic t_reset;
    rd(`PWP_B_CLR_OFS, 32'h00000002, OK);
    rd(`PWP_B_SET_OFS, 32'h00000002, OK);
    rd(`PWP_C_CLR_OFS, 32'h00100000, OK);
    rd(`PWP_C_SET_OFS, 32'h00100000, OK);
    flags(32'h00000002, 32'h00100000);
  endtask
  task automatic t_bank_b;
    wr(`PWP_B_SET_OFS, 32'h00000008, OK);
    wr(`PWP_B_CLR_OFS, 32'h00000002, OK);
    wr(`PWP_B_SET_OFS, 32'hfffffff5, OK);
    wr(`PWP_B_SET_OFS, 32'h00000000, OK);
    rd(`PWP_B_CLR_OFS, 32'h0000000c, OK);
  endtask
  task automatic t_double;
    wr(`PWP_B_SET_OFS, 32'h00000008, ER);
    wr(`PWP_B_CLR_OFS, 32'h00000002, ER);
    rd(`PWP_B_SET_OFS, 32'h0000000c, OK);
  endtask
  task automatic t_bank_c;
    wr(`PWP_C_SET_OFS, 32'h001ffffe, OK);
    rd(`PWP_C_CLR_OFS, 32'h001ffffe, OK);
    wr(`PWP_C_CLR_OFS, 32'h00100002, OK);
    rd(`PWP_C_SET_OFS, 32'h001ffffc, OK);
    // Only the low byte is strobed: bits 19:8 must stay protected
    s_wstrb <= 4'h1;
    wr(`PWP_C_CLR_OFS, 32'h001ff0f0, OK);
    s_wstrb <= 4'hf;
    wr(`PWP_C_CLR_OFS, 32'h00100010, ER);
    rd(`PWP_C_SET_OFS, 32'h001fff0c, OK);
    flags(32'h0000000c, 32'h001fff0c);
  endtask
  task automatic t_gate;
    gate(1'b1, 5'h01, 1'b0, 1'b1);
    gate(1'b1, 5'h13, 1'b0, 1'b0);
    gate(1'b1, 5'h13, 1'b1, 1'b1);
    gate(1'b0, 5'h03, 1'b0, 1'b0);
    gate(1'b0, 5'h01, 1'b0, 1'b1);
    gate(1'b1, 5'h14, 1'b0, 1'b1);
  endtask
  task automatic t_unmapped;
    wr(`PWP_TGT_OFS, 32'hffffffff, ER);
    rd(`PWP_ERR_OFS, 32'h00000000, ER);
    rd(`PWP_B_SET_OFS, 32'h0000000c, OK);
  endtask
  // A debugger attempt while frozen must not be answered
  task automatic t_freeze;
    clk_en <= 1'b0;
    core.attempt(1'b1, 5'h13, 1'b1);
    clk_en <= 1'b1;
    #1;
    chk("frozen allow", 32'h0, {31'h0, per_wr_allow});
  endtask
  task automatic t_rerst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      results();
    end
  end
  initial
  begin
    aresetn = 1'b0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    s_awaddr = 12'h000;
    s_araddr = 12'h000;
    s_wdata = 32'h00000000;
    s_wstrb = 4'hf;
    clk_en = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_bank_b();
    t_double();
    t_bank_c();
    t_gate();
    t_unmapped();
    t_freeze();
    t_rerst();
    results();
  end
endmodule // peripheral_write_protect_banks_tb_top
